// ===== rtl/ats_top.sv
// Contract
// - one-shot mode captures exactly one frame
// - one-shot ends itself after that frame
// - stop before a frame may end frameless
// - counted mode captures programmed frame total
// - link parameters locked while acquiring
// - continuous mode captures until stop command
// - stop mid-frame finishes the frame first
// - burst truncated to frames still remaining
// - burst length ignored in one-shot mode
// - counted mode caps burst by frames still remaining
// - frame pacing only when triggering off
// - pace rate writable and used only enabled
// - host fire acts only with host origin
// - triggers discarded unless armed indication true
// - accepted trigger waits programmed microsecond delay
// - overlap policy decides when trigger latches
// - integration time counted in microseconds
// - brightness target held as 8 bits
// - meter window on at 1, off at 0
// - meter window relative to user region
// - action checked by unit key, team key, mask
// - unconditional mode ignores closed control channel
`timescale 1ns/100ps
`default_nettype none
module ats_top #(
  parameter int unsigned READOUT = ats_pkg::READOUT_CYC
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic line_fire_in,
  input wire logic channel_open_in,
  input wire ats_pkg::ats_action_t action_in,
  output logic acquiring_out,
  output logic exposing_out,
  output logic fire_accept_ready_out,
  output logic frame_done_out
);
  ats_pkg::ats_ctrl_t ctrl;
  logic [15:0] capture_frame_total;
  logic [15:0] burst_length;
  logic [23:0] frame_pace_hz;
  logic [15:0] fire_wait_us;
  logic [23:0] integration_time_us;
  logic [7:0] auto_level_target;
  logic [15:0] meter_width;
  logic [15:0] meter_height;
  logic [15:0] meter_x;
  logic [15:0] meter_y;
  logic [31:0] action_unit_key;
  logic [31:0] action_team_key;
  logic [31:0] action_team_mask;
  logic [31:0] link_param;

  logic running;
  logic stop_pend;
  ats_pkg::ats_phase_t phase;
  logic [31:0] phase_cnt;
  logic [15:0] frames_left;
  logic [15:0] burst_left;
  logic [15:0] frames_done;
  logic dly_act;
  logic [31:0] dly_cnt;
  logic pace_pend;
  logic [31:0] pace_acc;
  logic line_prev;

  logic apb_do;
  logic wr_do;
  logic wr_bad;
  logic [31:0] rd_val;
  logic rd_bad;
  logic cmd_begin;
  logic cmd_end;
  logic cmd_fire;
  logic limited;
  logic armed;
  logic fire_event;
  logic fire_take;
  logic action_ok;
  logic delay_done;
  logic [15:0] burst_base;
  logic [15:0] burst_eff;
  logic start_frame;
  logic frame_end;
  logic seq_end;
  logic pace_run;
  logic [32:0] pace_sum;
  logic pace_tick;

  // access completes on the edge where pready is seen high
  assign apb_do = psel_in && penable_in && pready_out;
  assign wr_do = apb_do && pwrite_in && !pslverr_out;
  assign cmd_begin = wr_do && paddr_in == ats_pkg::OFS_CMD && pwdata_in[ats_pkg::CMD_BEGIN_BIT];
  assign cmd_end = wr_do && paddr_in == ats_pkg::OFS_CMD && pwdata_in[ats_pkg::CMD_END_BIT];
  assign cmd_fire = wr_do && paddr_in == ats_pkg::OFS_CMD && pwdata_in[ats_pkg::CMD_FIRE_BIT];

  always_comb begin
    wr_bad = 1'b0;
    case (paddr_in)
      ats_pkg::OFS_CTRL, ats_pkg::OFS_CMD, ats_pkg::OFS_FRAME_TOTAL, ats_pkg::OFS_BURST_LEN,
      ats_pkg::OFS_FIRE_WAIT, ats_pkg::OFS_INTEG, ats_pkg::OFS_LEVEL, ats_pkg::OFS_METER_SIZE,
      ats_pkg::OFS_METER_POS, ats_pkg::OFS_UNIT_KEY, ats_pkg::OFS_TEAM_KEY,
      ats_pkg::OFS_TEAM_MASK: wr_bad = 1'b0;
      ats_pkg::OFS_PACE_HZ: wr_bad = !ctrl.frame_pace_on;
      ats_pkg::OFS_LINK_PARAM: wr_bad = running;
      default: wr_bad = 1'b1;
    endcase
  end

  always_comb begin
    rd_val = 32'h00000000;
    rd_bad = 1'b0;
    case (paddr_in)
      ats_pkg::OFS_CTRL: rd_val = {23'h000000, ctrl};
      ats_pkg::OFS_CMD: rd_val = 32'h00000000;
      ats_pkg::OFS_FRAME_TOTAL: rd_val = {16'h0000, capture_frame_total};
      ats_pkg::OFS_BURST_LEN: rd_val = {16'h0000, burst_length};
      ats_pkg::OFS_PACE_HZ: rd_val = {8'h00, frame_pace_hz};
      ats_pkg::OFS_FIRE_WAIT: rd_val = {16'h0000, fire_wait_us};
      ats_pkg::OFS_INTEG: rd_val = {8'h00, integration_time_us};
      ats_pkg::OFS_LEVEL: rd_val = {24'h000000, auto_level_target};
      ats_pkg::OFS_METER_SIZE: rd_val = {meter_height, meter_width};
      ats_pkg::OFS_METER_POS: rd_val = {meter_y, meter_x};
      ats_pkg::OFS_UNIT_KEY: rd_val = action_unit_key;
      ats_pkg::OFS_TEAM_KEY: rd_val = action_team_key;
      ats_pkg::OFS_TEAM_MASK: rd_val = action_team_mask;
      ats_pkg::OFS_LINK_PARAM: rd_val = link_param;
      ats_pkg::OFS_STATUS: rd_val = {frames_done, 12'h000, phase == ats_pkg::PH_READ,
                                     phase == ats_pkg::PH_EXPOSE, armed, running};
      default: rd_bad = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else if (ce_in) begin
      // one wait state: pready rises in the second access cycle
      pready_out <= psel_in && penable_in && !pready_out;
      if (psel_in && penable_in && !pready_out) begin
        pslverr_out <= pwrite_in ? wr_bad : rd_bad;
        prdata_out <= pwrite_in ? 32'h00000000 : rd_val;
      end else begin
        pslverr_out <= 1'b0;
        prdata_out <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl <= '0;
      capture_frame_total <= ats_pkg::RST_FRAME_TOTAL;
      burst_length <= ats_pkg::RST_BURST_LEN;
      frame_pace_hz <= ats_pkg::RST_PACE_HZ;
      fire_wait_us <= ats_pkg::RST_FIRE_WAIT;
      integration_time_us <= ats_pkg::RST_INTEG;
      auto_level_target <= ats_pkg::RST_LEVEL;
      meter_width <= 16'h0000;
      meter_height <= 16'h0000;
      meter_x <= 16'h0000;
      meter_y <= 16'h0000;
      action_unit_key <= 32'h00000000;
      action_team_key <= 32'h00000000;
      action_team_mask <= 32'h00000000;
      link_param <= ats_pkg::RST_LINK_PARAM;
    end else if (ce_in && wr_do) begin
      case (paddr_in)
        ats_pkg::OFS_CTRL: ctrl <= pwdata_in[$bits(ats_pkg::ats_ctrl_t)-1:0];
        ats_pkg::OFS_FRAME_TOTAL: capture_frame_total <= pwdata_in[15:0];
        ats_pkg::OFS_BURST_LEN: burst_length <= pwdata_in[15:0];
        ats_pkg::OFS_PACE_HZ: frame_pace_hz <= pwdata_in[23:0];
        ats_pkg::OFS_FIRE_WAIT: fire_wait_us <= pwdata_in[15:0];
        ats_pkg::OFS_INTEG: integration_time_us <= pwdata_in[23:0];
        ats_pkg::OFS_LEVEL: auto_level_target <= pwdata_in[7:0];
        // offsets kept relative to user region
        ats_pkg::OFS_METER_SIZE: begin
          meter_width <= pwdata_in[15:0];
          meter_height <= pwdata_in[31:16];
        end
        ats_pkg::OFS_METER_POS: begin
          meter_x <= pwdata_in[15:0];
          meter_y <= pwdata_in[31:16];
        end
        ats_pkg::OFS_UNIT_KEY: action_unit_key <= pwdata_in;
        ats_pkg::OFS_TEAM_KEY: action_team_key <= pwdata_in;
        ats_pkg::OFS_TEAM_MASK: action_team_mask <= pwdata_in;
        ats_pkg::OFS_LINK_PARAM: link_param <= pwdata_in;
        default: link_param <= link_param;
      endcase
    end
  end

  assign limited = ctrl.capture_mode_select != ats_pkg::MODE_CONTINUOUS;

  assign action_ok = action_in.valid && action_in.unit_key == action_unit_key &&
                     action_in.team_key == action_team_key &&
                     (action_in.team_mask & action_team_mask) != 32'h00000000 &&
                     (channel_open_in || ctrl.action_ignore_channel_state);

  always_comb begin
    case (ctrl.fire_origin_select)
      ats_pkg::ORIGIN_LINE: fire_event = line_fire_in && !line_prev;
      ats_pkg::ORIGIN_HOST: fire_event = cmd_fire;
      ats_pkg::ORIGIN_ACTION: fire_event = action_ok;
      default: fire_event = 1'b0;
    endcase
  end

  // overlap lets a trigger latch during readout
  assign armed = running && !stop_pend && ctrl.triggered_operation_on && !dly_act &&
                 burst_left == 16'h0000 && (!limited || frames_left != 16'h0000) &&
                 (phase == ats_pkg::PH_IDLE ||
                  (ctrl.fire_overlap_policy && phase == ats_pkg::PH_READ));
  assign fire_take = fire_event && armed && fire_accept_ready_out;
  assign delay_done = dly_act && dly_cnt == 32'h00000000;

  always_comb begin
    burst_base = (burst_length == 16'h0000) ? 16'h0001 : burst_length;
    if (ctrl.capture_mode_select == ats_pkg::MODE_ONE_SHOT) begin
      burst_eff = 16'h0001;
    end else if (limited && frames_left < burst_base) begin
      burst_eff = frames_left;
    end else begin
      burst_eff = burst_base;
    end
  end

  assign pace_run = running && ctrl.frame_pace_on && !ctrl.triggered_operation_on;
  assign pace_sum = {1'b0, pace_acc} + {9'h000, frame_pace_hz};
  assign pace_tick = pace_run && pace_sum >= 33'(ats_pkg::CLK_HZ);

  assign start_frame = running && !stop_pend && phase == ats_pkg::PH_IDLE &&
                       (!limited || frames_left != 16'h0000) &&
                       (ctrl.triggered_operation_on ? burst_left != 16'h0000 :
                        (!ctrl.frame_pace_on || pace_pend));
  assign frame_end = phase == ats_pkg::PH_READ && phase_cnt == 32'h00000000;
  // stop pending or limited frame count used up, with no frame in flight
  assign seq_end = running && phase == ats_pkg::PH_IDLE &&
                   (stop_pend || (limited && frames_left == 16'h0000));

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      line_prev <= 1'b0;
    end else if (ce_in) begin
      line_prev <= line_fire_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      running <= 1'b0;
      stop_pend <= 1'b0;
    end else if (ce_in) begin
      if (!running && cmd_begin) begin
        running <= 1'b1;
        stop_pend <= 1'b0;
      end else if (seq_end) begin
        running <= 1'b0;
        stop_pend <= 1'b0;
      end else if (running && cmd_end) begin
        stop_pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      frames_left <= 16'h0000;
    end else if (ce_in) begin
      if (!running && cmd_begin) begin
        frames_left <= (ctrl.capture_mode_select == ats_pkg::MODE_ONE_SHOT) ? 16'h0001 :
                       capture_frame_total;
      end else if (start_frame && limited) begin
        frames_left <= frames_left - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      dly_act <= 1'b0;
      dly_cnt <= 32'h00000000;
    end else if (ce_in) begin
      if (!running) begin
        dly_act <= 1'b0;
        dly_cnt <= 32'h00000000;
      end else if (fire_take) begin
        dly_act <= 1'b1;
        dly_cnt <= 32'(fire_wait_us * ats_pkg::US_CYC);
      end else if (delay_done) begin
        dly_act <= 1'b0;
      end else if (dly_act) begin
        dly_cnt <= dly_cnt - 32'h00000001;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      burst_left <= 16'h0000;
    end else if (ce_in) begin
      if (!running || stop_pend) begin
        burst_left <= 16'h0000;
      end else if (delay_done) begin
        burst_left <= burst_eff;
      end else if (start_frame && burst_left != 16'h0000) begin
        burst_left <= burst_left - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pace_acc <= 32'h00000000;
      pace_pend <= 1'b0;
    end else if (ce_in) begin
      if (!pace_run) begin
        pace_acc <= 32'h00000000;
        pace_pend <= 1'b0;
      end else begin
        pace_acc <= pace_tick ? 32'(pace_sum - 33'(ats_pkg::CLK_HZ)) : pace_sum[31:0];
        // a tick landing on a frame start is kept, not lost
        if (pace_tick) begin
          pace_pend <= 1'b1;
        end else if (start_frame) begin
          pace_pend <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      phase <= ats_pkg::PH_IDLE;
      phase_cnt <= 32'h00000000;
      frames_done <= 16'h0000;
      frame_done_out <= 1'b0;
    end else if (ce_in) begin
      frame_done_out <= frame_end;
      if (!running && cmd_begin) begin
        frames_done <= 16'h0000;
      end else if (frame_end) begin
        frames_done <= frames_done + 16'h0001;
      end
      case (phase)
        ats_pkg::PH_IDLE: begin
          if (start_frame) begin
            phase <= ats_pkg::PH_EXPOSE;
            phase_cnt <= 32'(integration_time_us * ats_pkg::US_CYC);
          end
        end
        ats_pkg::PH_EXPOSE: begin
          if (phase_cnt == 32'h00000000) begin
            phase <= ats_pkg::PH_READ;
            phase_cnt <= 32'(READOUT);
          end else begin
            phase_cnt <= phase_cnt - 32'h00000001;
          end
        end
        ats_pkg::PH_READ: begin
          if (phase_cnt == 32'h00000000) begin
            phase <= ats_pkg::PH_IDLE;
          end else begin
            phase_cnt <= phase_cnt - 32'h00000001;
          end
        end
        default: phase <= ats_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      acquiring_out <= 1'b0;
      exposing_out <= 1'b0;
      fire_accept_ready_out <= 1'b0;
    end else if (ce_in) begin
      acquiring_out <= running;
      exposing_out <= phase == ats_pkg::PH_EXPOSE;
      fire_accept_ready_out <= armed;
    end
  end
endmodule : ats_top
`default_nettype wire

// ===== rtl/ats_pkg.sv
package ats_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned US_CYC = CLK_HZ / US_PER_S;
  localparam int unsigned READOUT_CYC = 64;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_FRAME_TOTAL = 8'h08;
  localparam logic [7:0] OFS_BURST_LEN = 8'h0C;
  localparam logic [7:0] OFS_PACE_HZ = 8'h10;
  localparam logic [7:0] OFS_FIRE_WAIT = 8'h14;
  localparam logic [7:0] OFS_INTEG = 8'h18;
  localparam logic [7:0] OFS_LEVEL = 8'h1C;
  localparam logic [7:0] OFS_METER_SIZE = 8'h20;
  localparam logic [7:0] OFS_METER_POS = 8'h24;
  localparam logic [7:0] OFS_UNIT_KEY = 8'h28;
  localparam logic [7:0] OFS_TEAM_KEY = 8'h2C;
  localparam logic [7:0] OFS_TEAM_MASK = 8'h30;
  localparam logic [7:0] OFS_LINK_PARAM = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;

  localparam int unsigned CMD_BEGIN_BIT = 0;
  localparam int unsigned CMD_END_BIT = 1;
  localparam int unsigned CMD_FIRE_BIT = 2;

  localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
  localparam logic [1:0] MODE_COUNTED = 2'h1;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h2;

  localparam logic [1:0] ORIGIN_LINE = 2'h0;
  localparam logic [1:0] ORIGIN_HOST = 2'h1;
  localparam logic [1:0] ORIGIN_ACTION = 2'h2;

  localparam logic [15:0] RST_FRAME_TOTAL = 16'h0001;
  localparam logic [15:0] RST_BURST_LEN = 16'h0001;
  localparam logic [23:0] RST_PACE_HZ = 24'h00001E;
  localparam logic [15:0] RST_FIRE_WAIT = 16'h0000;
  localparam logic [23:0] RST_INTEG = 24'h002710;
  localparam logic [7:0] RST_LEVEL = 8'h80;
  localparam logic [31:0] RST_LINK_PARAM = 32'h000005DC;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_EXPOSE = 2'b01,
    PH_READ = 2'b10
  } ats_phase_t;

  typedef struct packed {
    logic action_ignore_channel_state;
    logic meter_window_on;
    logic fire_overlap_policy;
    logic frame_pace_on;
    logic [1:0] fire_origin_select;
    logic triggered_operation_on;
    logic [1:0] capture_mode_select;
  } ats_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [31:0] unit_key;
    logic [31:0] team_key;
    logic [31:0] team_mask;
  } ats_action_t;
endpackage : ats_pkg

// ===== sim/ats_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ats_properties #(
  parameter int unsigned READOUT = 64
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic line_fire_in,
  input wire logic channel_open_in,
  input wire ats_pkg::ats_action_t action_in,
  input wire logic acquiring_out,
  input wire logic exposing_out,
  input wire logic fire_accept_ready_out,
  input wire logic frame_done_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // readout span after exposure, counted here to bound the done pulse
  logic gap_on;
  logic [7:0] gap_cnt;
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      gap_on <= 1'b0;
      gap_cnt <= 8'h00;
    end else if (ce_in) begin
      if (frame_done_out) begin
        gap_on <= 1'b0;
      end else if ($fell(exposing_out)) begin
        gap_on <= 1'b1;
        gap_cnt <= 8'h00;
      end else if (gap_on) begin
        gap_cnt <= gap_cnt + 8'h01;
      end
    end
  end
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
    else $error("pready outside access phase");
  rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data not zero when idle");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  link_lock_a: assert property (pready_out && pwrite_in && paddr_in == ats_pkg::OFS_LINK_PARAM
    && acquiring_out && $past(acquiring_out, 3) |-> pslverr_out)
    else $error("link parameter write accepted while acquiring");
  armed_run_a: assert property (fire_accept_ready_out |-> acquiring_out)
    else $error("armed while not acquiring");
  expose_run_a: assert property (exposing_out |-> acquiring_out)
    else $error("exposing outside acquisition");
  done_pulse_a: assert property (frame_done_out |=> !frame_done_out)
    else $error("frame done longer than one cycle");
  done_after_a: assert property (frame_done_out |-> gap_on && gap_cnt <= READOUT + 3)
    else $error("frame done not after exposure and readout");
endmodule : ats_properties
bind ats_top ats_properties #(.READOUT(READOUT)) u_props (.*);
`default_nettype wire

// ===== sim/ats_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ats_partner (
  input wire logic mclk_in,
  output logic line_fire_out,
  output ats_pkg::ats_action_t action_out
);
  initial begin
    line_fire_out = 1'b0;
    action_out = '0;
  end
  task automatic pulse_line();
    @(posedge mclk_in);
    line_fire_out <= 1'b1;
    repeat (3) @(posedge mclk_in);
    line_fire_out <= 1'b0;
  endtask : pulse_line
  // one-cycle message, then keys scrambled so stale values never match
  task automatic send(input logic [31:0] uk, input logic [31:0] tk, input logic [31:0] tm);
    @(posedge mclk_in);
    action_out <= {1'b1, uk, tk, tm};
    @(posedge mclk_in);
    action_out <= {1'b0, ~uk, ~tk, ~tm};
  endtask : send
endmodule : ats_partner
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk_in, srst_in, psel, penable, pwrite, pready, pslverr, line_fire, chan_open;
  logic acquiring, exposing, armed, done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  logic ce;
  ats_pkg::ats_action_t action;
  int n_fail = 0;
  int compares = 0;
  int frames = 0;
  ats_top #(.READOUT(4)) u_dut (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .line_fire_in(line_fire), .channel_open_in(chan_open), .action_in(action),
    .acquiring_out(acquiring), .exposing_out(exposing), .fire_accept_ready_out(armed),
    .frame_done_out(done));
  ats_partner u_far (.mclk_in(mclk_in), .line_fire_out(line_fire), .action_out(action));
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) if (done === 1'b1) frames++;
  task automatic close_out();
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : apb
  task automatic wait_for(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 3000) chk(32'h0, 32'h1);
  endtask : wait_for
  task automatic run_end();
    int n;
    repeat (4) @(posedge mclk_in);
    wait_for(acquiring, 1'b0, n);
  endtask : run_end
  function automatic logic [31:0] cw(logic [1:0] m, logic t, logic [1:0] o, logic ign);
    ats_pkg::ats_ctrl_t c;
    c = '0;
    c.capture_mode_select = m;
    c.triggered_operation_on = t;
    c.fire_origin_select = o;
    c.action_ignore_channel_state = ign;
    return 32'(c);
  endfunction : cw
  task automatic t_regs();
    apb(0, ats_pkg::OFS_FRAME_TOTAL, 0); chk(rd, 32'h1);
    apb(0, ats_pkg::OFS_INTEG, 0); chk(rd, 32'h2710);
    apb(0, ats_pkg::OFS_LINK_PARAM, 0); chk(rd, 32'h5DC);
    apb(1, ats_pkg::OFS_LEVEL, 32'h1FF);
    apb(0, ats_pkg::OFS_LEVEL, 0); chk(rd, 32'hFF);
    apb(1, ats_pkg::OFS_CTRL, 32'h80);
    apb(0, ats_pkg::OFS_CTRL, 0); chk(rd, 32'h80);
    apb(0, 8'h3C, 0); chk({31'h0, err}, 32'h1);
  endtask : t_regs
  task automatic t_one_shot();
    apb(1, ats_pkg::OFS_INTEG, 32'h2);
    apb(1, ats_pkg::OFS_BURST_LEN, 32'h5);
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_ONE_SHOT, 0, 0, 0));
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    run_end(); chk(frames, 1);
  endtask : t_one_shot
  task automatic t_counted();
    apb(1, ats_pkg::OFS_FRAME_TOTAL, 32'h3);
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_COUNTED, 0, 0, 0));
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    apb(1, ats_pkg::OFS_LINK_PARAM, 32'h7); chk({31'h0, err}, 32'h1);
    run_end(); chk(frames, 3);
    apb(0, ats_pkg::OFS_LINK_PARAM, 0); chk(rd, 32'h5DC);
  endtask : t_counted
  task automatic t_stop();
    int n, f;
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_CONTINUOUS, 0, 0, 0));
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    repeat (80) @(posedge mclk_in);
    wait_for(exposing, 1'b1, n);
    f = frames;
    // a frozen clock enable must hold the frame mid-exposure
    ce <= 1'b0;
    repeat (40) @(posedge mclk_in);
    chk({31'h0, exposing}, 32'h1);
    chk(frames, f);
    ce <= 1'b1;
    apb(1, ats_pkg::OFS_CMD, 32'h2);
    run_end(); chk(frames, f + 1);
    chk(f >= 2, 1);
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_CONTINUOUS, 1, ats_pkg::ORIGIN_HOST, 0));
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    apb(1, ats_pkg::OFS_CMD, 32'h2);
    run_end(); chk(frames, 0);
  endtask : t_stop
  task automatic t_trig();
    int n;
    apb(1, ats_pkg::OFS_FIRE_WAIT, 32'h2);
    apb(1, ats_pkg::OFS_BURST_LEN, 32'h2);
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_COUNTED, 1, ats_pkg::ORIGIN_HOST, 0));
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h4);
    repeat (60) @(posedge mclk_in); chk(frames, 0);
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    wait_for(armed, 1'b1, n);
    apb(1, ats_pkg::OFS_CMD, 32'h4);
    wait_for(exposing, 1'b1, n); chk(n >= 20 && n <= 30, 1);
    wait_for(armed, 1'b1, n); chk(frames, 2);
    apb(1, ats_pkg::OFS_CMD, 32'h4);
    run_end(); chk(frames, 3);
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_COUNTED, 1, ats_pkg::ORIGIN_LINE, 0));
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    wait_for(armed, 1'b1, n);
    apb(1, ats_pkg::OFS_CMD, 32'h4);
    repeat (80) @(posedge mclk_in); chk(frames, 0);
    u_far.pulse_line();
    repeat (120) @(posedge mclk_in); chk(frames, 2);
    apb(1, ats_pkg::OFS_CMD, 32'h2);
    run_end(); chk(frames, 2);
  endtask : t_trig
  task automatic t_overlap();
    int n;
    apb(1, ats_pkg::OFS_FRAME_TOTAL, 32'h2);
    apb(1, ats_pkg::OFS_BURST_LEN, 32'h1);
    // bit 6 of the control word is the overlap policy
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_COUNTED, 1, ats_pkg::ORIGIN_HOST, 0) | 32'h40);
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    wait_for(armed, 1'b1, n);
    apb(1, ats_pkg::OFS_CMD, 32'h4);
    wait_for(exposing, 1'b1, n);
    wait_for(exposing, 1'b0, n);
    @(posedge mclk_in);
    chk({31'h0, armed}, 32'h1);
    chk(frames, 0);
    apb(1, ats_pkg::OFS_CMD, 32'h4);
    run_end(); chk(frames, 2);
  endtask : t_overlap
  task automatic t_action();
    int n;
    apb(1, ats_pkg::OFS_UNIT_KEY, 32'h11);
    apb(1, ats_pkg::OFS_TEAM_KEY, 32'h22);
    apb(1, ats_pkg::OFS_TEAM_MASK, 32'h0F);
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_ONE_SHOT, 1, ats_pkg::ORIGIN_ACTION, 0));
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    wait_for(armed, 1'b1, n);
    u_far.send(32'h12, 32'h22, 32'h1);
    u_far.send(32'h11, 32'h23, 32'h1);
    u_far.send(32'h11, 32'h22, 32'h10);
    chan_open <= 1'b0;
    u_far.send(32'h11, 32'h22, 32'h1);
    repeat (60) @(posedge mclk_in); chk(frames, 0);
    apb(1, ats_pkg::OFS_CTRL, cw(ats_pkg::MODE_ONE_SHOT, 1, ats_pkg::ORIGIN_ACTION, 1));
    u_far.send(32'h11, 32'h22, 32'h1);
    run_end(); chk(frames, 1);
  endtask : t_action
  task automatic t_pace();
    int n;
    apb(1, ats_pkg::OFS_PACE_HZ, 32'h10); chk({31'h0, err}, 32'h1);
    apb(1, ats_pkg::OFS_CTRL, 32'h21);
    apb(1, ats_pkg::OFS_PACE_HZ, 32'h186A0); chk({31'h0, err}, 32'h0);
    apb(1, ats_pkg::OFS_FRAME_TOTAL, 32'h2);
    frames = 0;
    apb(1, ats_pkg::OFS_CMD, 32'h1);
    wait_for(done, 1'b1, n);
    @(posedge mclk_in);
    wait_for(done, 1'b1, n); chk(n >= 95, 1);
    run_end();
  endtask : t_pace
  initial begin
    srst_in = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    chan_open = 1'b1;
    ce = 1'b1;
    repeat (5) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_regs();
    t_one_shot();
    t_counted();
    t_stop();
    t_trig();
    t_overlap();
    t_action();
    t_pace();
    close_out();
  end
  // whole run is a few thousand cycles; this margin only catches a hang
  initial begin
    repeat (60000) @(posedge mclk_in);
    n_fail++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
